/* rtl/pin_edge_sync.sv */
// Two-flop synchroniser with edge detection for one external pin
module pin_edge_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // Two flops, then one more stage for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edges from the settled stages only
    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;
endmodule : pin_edge_sync

/* rtl/usart_slave_map.svh */
// Register map, field positions, reset values and sizes of the synchronous slave serial port
//
// What this block does
// - Slave operation runs only while clock source select, transmit status bit 7, is clear.
// - Shifters keep transmitting and receiving while the core sleeps.
// - Of two buffered words the first moves to the shifter at once; buffer-free stays clear.
// - When the first word is shifted out, the second loads and buffer-free sets.
// - Rising buffer-free wakes the core when transmit and peripheral enables are set.
// - After wake, global enable picks the 0004h vector, else the next instruction.
// - Single receive enable is ignored; only continuous receive enable runs the receiver.
// - With continuous receive enabled before sleep, a whole word is received while asleep.
// - A fully received word moves from the receive shifter into the receive FIFO.
// - Receive event wakes the core when receive and peripheral enables are set.
// - Receive ready sets when a word completes; interrupt only with receive enable.
// - Clearing continuous receive enable clears the error flags.
// - Received data is sampled on the falling edge of the shift clock.
// - FIFO holds two words; a third while full sets overrun and is discarded.
// - While overrun is set, no word enters the FIFO.
// - Ninth bit travels with each FIFO entry; reading the byte exposes the next one.
`ifndef USART_SLAVE_MAP_SVH
`define USART_SLAVE_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_INTERRUPT_CONTROL       8'h0b
`define IDX_PERIPHERAL_IRQ_FLAGS    8'h0c
`define IDX_RECEIVE_STATUS_CONTROL  8'h18
`define IDX_TRANSMIT_HOLDING_BUFFER 8'h19
`define IDX_RECEIVE_FIFO_DATA       8'h1a
`define IDX_PERIPHERAL_IRQ_ENABLES  8'h8c
`define IDX_TRANSMIT_STATUS_CONTROL 8'h98
`define IDX_BAUD_RATE_DIVISOR       8'h99

// Reset values
`define RST_INTERRUPT_CONTROL       8'h00
`define RST_PERIPHERAL_IRQ_FLAGS    8'h00
`define RST_RECEIVE_STATUS_CONTROL  8'h00
`define RST_PERIPHERAL_IRQ_ENABLES  8'h00
`define RST_TRANSMIT_STATUS_CONTROL 8'h02
`define RST_BAUD_RATE_DIVISOR       8'h00

// Interrupt control fields
`define BIT_GLOBAL_IRQ_ENABLE       7
`define BIT_PERIPHERAL_IRQ_ENABLE   6
// Flag and enable fields
`define BIT_RECEIVE_READY           5
`define BIT_TRANSMIT_BUFFER_FREE    4
// Receive status/control fields
`define BIT_SERIAL_PORT_ENABLE      7
`define BIT_RECEIVE_NINE_BIT_MODE   6
`define BIT_SINGLE_RECEIVE_ENABLE   5
`define BIT_CONTINUOUS_RX_ENABLE    4
`define BIT_FRAMING_ERROR           2
`define BIT_OVERRUN_ERROR           1
`define BIT_RECEIVE_NINTH_VALUE     0
// Transmit status/control fields
`define BIT_CLOCK_SOURCE_SELECT     7
`define BIT_TRANSMIT_NINE_BIT_MODE  6
`define BIT_TRANSMIT_ENABLE         5
`define BIT_SYNC_MODE               4
`define BIT_HIGH_BAUD               2
`define BIT_SHIFTER_EMPTY           1
`define BIT_TRANSMIT_NINTH_VALUE    0

// Sizes
`define RX_FIFO_DEPTH               2
`define BITS_SHORT_WORD             4'd8
`define BITS_LONG_WORD              4'd9
`define WAKE_VECTOR_ADDRESS         13'h0004

`endif

/* rtl/usart_slave_pkg.sv */
// Types shared by the synchronous slave serial port
package usart_slave_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [8:0] word9_t;
    typedef logic [3:0] bit_count_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage : usart_slave_pkg

/* rtl/usart_sync_slave.sv */
// Synchronous slave serial port with APB register access
//
// The APB slave port was chosen for this implementation.
`include "usart_slave_map.svh"

module usart_sync_slave #(
    parameter int ADDR_W = 12
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   shift_clock_pin,
    input  wire logic                   serial_data_in,
    output logic                        serial_data_out,
    output logic                        serial_data_oe,
    input  wire logic                   sleep_mode,
    output logic                        wake_request,
    output logic                        wake_to_vector
);
    import usart_slave_pkg::*;

    localparam logic [ADDR_W-1:0] A_INTCTL = ADDR_W'({`IDX_INTERRUPT_CONTROL, 2'b00});
    localparam logic [ADDR_W-1:0] A_FLAGS  = ADDR_W'({`IDX_PERIPHERAL_IRQ_FLAGS, 2'b00});
    localparam logic [ADDR_W-1:0] A_RXSC   = ADDR_W'({`IDX_RECEIVE_STATUS_CONTROL, 2'b00});
    localparam logic [ADDR_W-1:0] A_TXBUF  = ADDR_W'({`IDX_TRANSMIT_HOLDING_BUFFER, 2'b00});
    localparam logic [ADDR_W-1:0] A_RXDATA = ADDR_W'({`IDX_RECEIVE_FIFO_DATA, 2'b00});
    localparam logic [ADDR_W-1:0] A_ENABLE = ADDR_W'({`IDX_PERIPHERAL_IRQ_ENABLES, 2'b00});
    localparam logic [ADDR_W-1:0] A_TXSC   = ADDR_W'({`IDX_TRANSMIT_STATUS_CONTROL, 2'b00});
    localparam logic [ADDR_W-1:0] A_BAUD   = ADDR_W'({`IDX_BAUD_RATE_DIVISOR, 2'b00});

    // Software-visible storage
    byte_t      interrupt_control_reg;
    byte_t      peripheral_irq_flags_reg;
    byte_t      peripheral_irq_enables_reg;
    byte_t      receive_status_control_reg;
    byte_t      transmit_status_control_reg;
    byte_t      baud_rate_divisor_reg;
    logic       overrun_error_reg;
    // Transmit path
    byte_t      hold_data_reg;
    logic       hold_ninth_reg;
    logic       hold_full_reg;
    word9_t     tx_shift_reg;
    bit_count_t tx_left_reg;
    tx_state_t  tx_state_reg;
    // Receive path
    word9_t     rx_shift_reg;
    bit_count_t rx_count_reg;
    word9_t     fifo_mem_reg [`RX_FIFO_DEPTH];
    logic       fifo_wr_reg;
    logic       fifo_rd_reg;
    logic [1:0] fifo_count_reg;
    // Wake tracking
    logic       transmit_buffer_free_flag_prev_reg;
    logic       receive_ready_flag_prev_reg;
    // APB answer
    logic       answer_reg;

    logic       clk_level, clk_rise, clk_fall;
    logic       din_level;
    logic       slave_active, tx_enabled, rx_enabled;
    logic       wr_done, rd_done, hit;
    logic       tx_load_first, tx_last_fall, tx_load_next;
    logic       rx_done, fifo_push, fifo_pop, fifo_full;
    bit_count_t rx_count_next, word_bits_rx, word_bits_tx;
    word9_t     rx_shift_next, rx_word;
    logic       transmit_buffer_free_flag, receive_ready_flag, global_irq_enable, peripheral_irq_enable, transmit_irq_enable, receive_irq_enable, continuous_receive_enable, serial_port_enable;
    logic       tx_wake_event, rx_wake_event;
    byte_t      read_mux;

    // Pin synchronisers; the shift clock is only ever an input here
    pin_edge_sync u_clk_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (shift_clock_pin),
        .level   (clk_level),
        .rise    (clk_rise),
        .fall    (clk_fall)
    );
    pin_edge_sync u_data_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (serial_data_in),
        .level   (din_level),
        .rise    (),
        .fall    ()
    );

    // Field decode
    assign global_irq_enable  = interrupt_control_reg[`BIT_GLOBAL_IRQ_ENABLE];
    assign peripheral_irq_enable = interrupt_control_reg[`BIT_PERIPHERAL_IRQ_ENABLE];
    assign transmit_irq_enable = peripheral_irq_enables_reg[`BIT_TRANSMIT_BUFFER_FREE];
    assign receive_irq_enable = peripheral_irq_enables_reg[`BIT_RECEIVE_READY];
    assign serial_port_enable = receive_status_control_reg[`BIT_SERIAL_PORT_ENABLE];
    assign continuous_receive_enable = receive_status_control_reg[`BIT_CONTINUOUS_RX_ENABLE];
    // Slave mode needs port on, sync mode and clock select clear
    assign slave_active = serial_port_enable & transmit_status_control_reg[`BIT_SYNC_MODE]
                        & ~transmit_status_control_reg[`BIT_CLOCK_SOURCE_SELECT];
    assign tx_enabled   = slave_active & transmit_status_control_reg[`BIT_TRANSMIT_ENABLE];
    // Single receive enable plays no part in slave reception
    assign rx_enabled   = slave_active & continuous_receive_enable;
    assign word_bits_tx = transmit_status_control_reg[`BIT_TRANSMIT_NINE_BIT_MODE] ?
                          `BITS_LONG_WORD : `BITS_SHORT_WORD;
    assign word_bits_rx = receive_status_control_reg[`BIT_RECEIVE_NINE_BIT_MODE] ?
                          `BITS_LONG_WORD : `BITS_SHORT_WORD;
    assign transmit_buffer_free_flag = ~hold_full_reg;
    assign receive_ready_flag = (fifo_count_reg != 2'd0);

    // APB strobes: writes and read side effects happen on the completing edge
    assign wr_done = psel & penable & answer_reg & pwrite;
    assign rd_done = psel & penable & answer_reg & ~pwrite;
    assign hit     = (paddr == A_INTCTL) | (paddr == A_FLAGS) | (paddr == A_RXSC) |
                     (paddr == A_TXBUF) | (paddr == A_RXDATA) | (paddr == A_ENABLE) |
                     (paddr == A_TXSC) | (paddr == A_BAUD);

    // Transmit sequencing: first word loads at once, next word on the last bit
    assign tx_load_first = tx_enabled & hold_full_reg & (tx_state_reg == TX_IDLE);
    assign tx_last_fall  = (tx_state_reg == TX_SHIFT) & clk_fall & (tx_left_reg == 4'd1);
    assign tx_load_next  = tx_last_fall & hold_full_reg & tx_enabled;

    // Receive shifting on falling shift clock, LSB arrives first
    assign rx_shift_next = {din_level, rx_shift_reg[8:1]};
    assign rx_count_next = rx_count_reg + 4'd1;
    assign rx_done       = rx_enabled & clk_fall & (rx_count_next == word_bits_rx);
    assign rx_word       = (word_bits_rx == `BITS_LONG_WORD) ? rx_shift_next :
                           {1'b0, rx_shift_next[8:1]};
    assign fifo_full     = (fifo_count_reg == 2'd`RX_FIFO_DEPTH);
    assign fifo_push     = rx_done & ~fifo_full & ~overrun_error_reg;
    assign fifo_pop      = rd_done & (paddr == A_RXDATA) & receive_ready_flag;

    // Wake events seen in the pclk domain from already synchronised shifter activity
    assign tx_wake_event = transmit_buffer_free_flag & ~transmit_buffer_free_flag_prev_reg & transmit_irq_enable & peripheral_irq_enable;
    assign rx_wake_event = receive_ready_flag & ~receive_ready_flag_prev_reg & receive_irq_enable & peripheral_irq_enable;

    // Read data mux; receive ninth bit shows the head entry
    always_comb begin
        read_mux = 8'h00;
        case (paddr)
            A_INTCTL: read_mux = interrupt_control_reg;
            A_FLAGS: begin
                read_mux = peripheral_irq_flags_reg;
                read_mux[`BIT_RECEIVE_READY]        = receive_ready_flag;
                read_mux[`BIT_TRANSMIT_BUFFER_FREE] = transmit_buffer_free_flag;
            end
            A_RXSC: begin
                read_mux = receive_status_control_reg;
                read_mux[3] = 1'b0;
                read_mux[`BIT_FRAMING_ERROR]       = 1'b0;
                read_mux[`BIT_OVERRUN_ERROR]       = overrun_error_reg;
                read_mux[`BIT_RECEIVE_NINTH_VALUE] = fifo_mem_reg[fifo_rd_reg][8];
            end
            A_RXDATA: read_mux = fifo_mem_reg[fifo_rd_reg][7:0];
            A_ENABLE: read_mux = peripheral_irq_enables_reg;
            A_TXSC: begin
                read_mux = transmit_status_control_reg;
                read_mux[3] = 1'b0;
                read_mux[`BIT_SHIFTER_EMPTY] = (tx_state_reg == TX_IDLE);
            end
            A_BAUD: read_mux = baud_rate_divisor_reg;
            default: read_mux = 8'h00;
        endcase
    end

    // APB answer: one wait-free access phase, registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            answer_reg <= 1'b0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
        end else begin
            answer_reg <= psel & ~penable & ~answer_reg;
            pready     <= psel & ~penable & ~answer_reg;
            pslverr    <= psel & ~penable & ~answer_reg & ~hit;
            if (psel & ~penable & ~answer_reg) begin
                prdata <= {24'h00_0000, read_mux};
            end
        end
    end

    // Control registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_control_reg       <= `RST_INTERRUPT_CONTROL;
            peripheral_irq_flags_reg    <= `RST_PERIPHERAL_IRQ_FLAGS;
            peripheral_irq_enables_reg  <= `RST_PERIPHERAL_IRQ_ENABLES;
            receive_status_control_reg  <= `RST_RECEIVE_STATUS_CONTROL;
            transmit_status_control_reg <= `RST_TRANSMIT_STATUS_CONTROL;
            baud_rate_divisor_reg       <= `RST_BAUD_RATE_DIVISOR;
        end else if (wr_done) begin
            case (paddr)
                A_INTCTL: interrupt_control_reg      <= pwdata[7:0];
                A_FLAGS:  peripheral_irq_flags_reg   <= pwdata[7:0];
                A_ENABLE: peripheral_irq_enables_reg <= pwdata[7:0];
                A_RXSC:   receive_status_control_reg <= pwdata[7:0];
                A_TXSC:   transmit_status_control_reg <= pwdata[7:0];
                A_BAUD:   baud_rate_divisor_reg      <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Holding buffer; ninth bit captured with the byte write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_data_reg  <= 8'h00;
            hold_ninth_reg <= 1'b0;
            hold_full_reg  <= 1'b0;
        end else if (wr_done & (paddr == A_TXBUF)) begin
            hold_data_reg  <= pwdata[7:0];
            hold_ninth_reg <= transmit_status_control_reg[`BIT_TRANSMIT_NINTH_VALUE];
            hold_full_reg  <= 1'b1;
        end else if (tx_load_first | tx_load_next) begin
            hold_full_reg  <= 1'b0;
        end
    end

    // Transmit shifter runs off the external clock regardless of sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg    <= TX_IDLE;
            tx_shift_reg    <= 9'h000;
            tx_left_reg     <= 4'd0;
            serial_data_out <= 1'b0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_load_first) begin
                        tx_state_reg    <= TX_SHIFT;
                        tx_shift_reg    <= {hold_ninth_reg, hold_data_reg};
                        tx_left_reg     <= word_bits_tx;
                        serial_data_out <= hold_data_reg[0];
                    end
                end
                TX_SHIFT: begin
                    if (!tx_enabled) begin
                        tx_state_reg <= TX_IDLE;
                    end else if (tx_load_next) begin
                        tx_shift_reg    <= {hold_ninth_reg, hold_data_reg};
                        tx_left_reg     <= word_bits_tx;
                        serial_data_out <= hold_data_reg[0];
                    end else if (tx_last_fall) begin
                        tx_state_reg <= TX_IDLE;
                    end else if (clk_fall) begin
                        // One bit per clock, ninth bit comes out last
                        tx_shift_reg    <= {1'b0, tx_shift_reg[8:1]};
                        tx_left_reg     <= tx_left_reg - 4'd1;
                        serial_data_out <= tx_shift_reg[1];
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // Data pin driven only while transmitting in slave mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_data_oe <= 1'b0;
        end else begin
            serial_data_oe <= tx_enabled & ~continuous_receive_enable;
        end
    end

    // Receive shifter; count clears whenever the receiver is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift_reg <= 9'h000;
            rx_count_reg <= 4'd0;
        end else if (!rx_enabled) begin
            rx_count_reg <= 4'd0;
        end else if (clk_fall) begin
            rx_shift_reg <= rx_shift_next;
            rx_count_reg <= rx_done ? 4'd0 : rx_count_next;
        end
    end

    // Overrun: set on a word arriving at a full FIFO, cleared with continuous enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_error_reg <= 1'b0;
        end else if (!continuous_receive_enable) begin
            overrun_error_reg <= 1'b0;
        end else if (rx_done & fifo_full) begin
            overrun_error_reg <= 1'b1;
        end
    end

    // Two-entry receive FIFO, ninth bit stored with each byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_mem_reg[0] <= 9'h000;
            fifo_mem_reg[1] <= 9'h000;
            fifo_wr_reg     <= 1'b0;
            fifo_rd_reg     <= 1'b0;
            fifo_count_reg  <= 2'd0;
        end else begin
            if (fifo_push) begin
                fifo_mem_reg[fifo_wr_reg] <= rx_word;
                fifo_wr_reg <= ~fifo_wr_reg;
            end
            if (fifo_pop) begin
                fifo_rd_reg <= ~fifo_rd_reg;
            end
            fifo_count_reg <= fifo_count_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // Wake request held until the core leaves sleep; vector choice follows global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_buffer_free_flag_prev_reg  <= 1'b1;
            receive_ready_flag_prev_reg  <= 1'b0;
            wake_request   <= 1'b0;
            wake_to_vector <= 1'b0;
        end else begin
            transmit_buffer_free_flag_prev_reg <= transmit_buffer_free_flag;
            receive_ready_flag_prev_reg <= receive_ready_flag;
            if (!sleep_mode) begin
                wake_request <= 1'b0;
            end else if (tx_wake_event | rx_wake_event) begin
                wake_request   <= 1'b1;
                wake_to_vector <= global_irq_enable;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_bit_with_next;
        tx_last_fall && hold_full_reg && tx_enabled;
    endsequence

    chk_oe_needs_slave: assert property (serial_data_oe |-> $past(slave_active))
        else $error("data pin driven outside slave mode");
    chk_first_load_now: assert property (tx_load_first |=> tx_state_reg == TX_SHIFT && !hold_full_reg)
        else $error("first word did not move to shifter");
    chk_second_load: assert property (s_last_bit_with_next |=> tx_state_reg == TX_SHIFT
                                      && transmit_buffer_free_flag && tx_left_reg == $past(word_bits_tx))
        else $error("buffered word not chained on last bit");
    chk_tx_wake: assert property (sleep_mode && tx_wake_event |=> wake_request)
        else $error("transmit event did not wake core");
    chk_wake_vector: assert property ($rose(wake_request) |-> wake_to_vector == $past(global_irq_enable))
        else $error("wake vector choice wrong");
    chk_rx_idle_off: assert property (!continuous_receive_enable |=> rx_count_reg == 4'd0)
        else $error("receiver ran without continuous enable");
    chk_fifo_push: assert property (fifo_push && !fifo_pop |=> fifo_count_reg == $past(fifo_count_reg)+2'd1)
        else $error("received word not stored");
    chk_overrun_set: assert property (rx_done && fifo_full && continuous_receive_enable |=> overrun_error_reg
                                      && fifo_count_reg == $past(fifo_count_reg) - {1'b0, $past(fifo_pop)})
        else $error("overrun not flagged or word kept");
    chk_overrun_block: assert property (overrun_error_reg |-> !fifo_push)
        else $error("FIFO written during overrun");
    chk_continuous_receive_enable_clear: assert property (!continuous_receive_enable |=> !overrun_error_reg)
        else $error("errors not cleared with continuous enable");
    chk_rx_wake: assert property (sleep_mode && rx_wake_event |=> wake_request)
        else $error("receive event did not wake core");
endmodule : usart_sync_slave

/* testbench/sync_master_model.sv */
// Behavioural synchronous master driving the shift clock and data pin
module sync_master_model (
    input  wire logic pclk,
    output logic      shift_clock_pin,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock idles high and stands still between frames
    initial begin
        shift_clock_pin = 1'b1;
        serial_data_in  = 1'b0;
    end
    // One frame of nbits 200 ns bits, LSB first; the port's bit is taken before the fall
    task automatic frame(input logic [8:0] tx, input int nbits, output logic [8:0] rx);
        rx = 9'h000;
        for (int i = 0; i < nbits; i++) begin
            @(posedge pclk) serial_data_in <= tx[i];
            repeat (3) @(posedge pclk);
            rx[i] = serial_data_out;
            shift_clock_pin <= 1'b0;
            repeat (4) @(posedge pclk);
            shift_clock_pin <= 1'b1;
        end
        serial_data_in <= ~tx[nbits-1]; // Released line shows no stale bit
    endtask : frame
endmodule : sync_master_model

/* testbench/tb_top.sv */
// Self-checking bench for the synchronous slave serial port
`include "usart_slave_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, sleep_mode, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, shift_clk, data_in, data_out, data_oe, wake_request, wake_to_vector;
    logic [8:0]  got;
    int          fail_count, tests_run;
    logic [15:0] rows [7] = '{16'h0b00, 16'h1800, 16'h1a00, 16'h8c00, 16'h9802, 16'h9900, 16'hff00};
    logic [7:0]  rx_bytes [3] = '{8'h11, 8'h22, 8'h33};
    usart_sync_slave usart_sync_slave_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shift_clock_pin(shift_clk), .serial_data_in(data_in),
        .serial_data_out(data_out), .serial_data_oe(data_oe), .sleep_mode(sleep_mode),
        .wake_request(wake_request), .wake_to_vector(wake_to_vector));
    sync_master_model sync_master_model_i (.pclk(pclk), .shift_clock_pin(shift_clk),
        .serial_data_in(data_in), .serial_data_out(data_out));
    // 40 MHz core clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
        if (n == 16) begin
            fail_count++;
            print_verdict();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        {presetn, psel, penable, pwrite, sleep_mode} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        // Reset values, unmapped place last
        foreach (rows[i]) begin
            apb(1'b0, rows[i][15:8], 8'h00);
            check(rd, {24'h0, rows[i][7:0]});
        end
        check({31'h0, err}, 32'h1);
        // Two buffered words, then sleep
        apb(1'b1, `IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        apb(1'b1, `IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
        apb(1'b1, `IDX_PERIPHERAL_IRQ_ENABLES, 8'h10);
        apb(1'b1, `IDX_INTERRUPT_CONTROL, 8'h40);
        apb(1'b1, `IDX_TRANSMIT_HOLDING_BUFFER, 8'ha5);
        apb(1'b1, `IDX_TRANSMIT_HOLDING_BUFFER, 8'h3c);
        sleep_mode <= 1'b1;
        apb(1'b0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check(rd & 32'h10, 32'h0);
        check({30'h0, wake_request, data_oe}, 32'h1);
        sync_master_model_i.frame(9'h000, 8, got);
        check({23'h0, got}, 32'ha5);
        repeat (8) @(posedge pclk);
        check({30'h0, wake_request, wake_to_vector}, 32'h2);
        apb(1'b0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check(rd & 32'h10, 32'h10);
        sync_master_model_i.frame(9'h000, 8, got);
        check({23'h0, got}, 32'h3c);
        // Nine-bit transmit: ninth value set before the byte, sent last
        apb(1'b1, `IDX_TRANSMIT_STATUS_CONTROL, 8'h71);
        apb(1'b1, `IDX_TRANSMIT_HOLDING_BUFFER, 8'h5a);
        sync_master_model_i.frame(9'h000, 9, got);
        check({23'h0, got}, 32'h15a);
        // Single receive enable alone receives nothing
        sleep_mode <= 1'b0;
        apb(1'b1, `IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
        apb(1'b1, `IDX_RECEIVE_STATUS_CONTROL, 8'ha0);
        sync_master_model_i.frame(9'h011, 8, got);
        apb(1'b0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check(rd & 32'h20, 32'h0);
        // Three words while asleep: third overruns
        apb(1'b1, `IDX_PERIPHERAL_IRQ_ENABLES, 8'h20);
        apb(1'b1, `IDX_INTERRUPT_CONTROL, 8'hc0);
        apb(1'b1, `IDX_RECEIVE_STATUS_CONTROL, 8'h90);
        sleep_mode <= 1'b1;
        foreach (rx_bytes[i]) sync_master_model_i.frame({1'b0, rx_bytes[i]}, 8, got);
        check({30'h0, wake_request, wake_to_vector}, 32'h3);
        apb(1'b0, `IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        check(rd, 32'h92);
        apb(1'b0, `IDX_RECEIVE_FIFO_DATA, 8'h00);
        check(rd, 32'h11);
        apb(1'b0, `IDX_RECEIVE_FIFO_DATA, 8'h00);
        check(rd, 32'h22);
        apb(1'b0, `IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
        check(rd & 32'h20, 32'h0);
        apb(1'b1, `IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        apb(1'b0, `IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        check(rd, 32'h80);
        // Nine-bit word with receive interrupt off: no wake, ninth bit travels with the byte
        sleep_mode <= 1'b0;
        apb(1'b1, `IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
        apb(1'b1, `IDX_RECEIVE_STATUS_CONTROL, 8'hd0);
        sleep_mode <= 1'b1;
        sync_master_model_i.frame(9'h1c3, 9, got);
        apb(1'b0, `IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        check({wake_request, rd[30:0]}, 32'hd1);
        apb(1'b0, `IDX_RECEIVE_FIFO_DATA, 8'h00);
        check(rd, 32'hc3);
        // Reset in mid-run returns to defaults
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, `IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
        check({wake_request, data_oe, rd[29:0]}, 32'h02);
        print_verdict();
    end
endmodule : tb_top
